// ===== sbm_defines.vh
// Constants for the single cycle byte multiplier
`ifndef SBM_DEFINES_VH
`define SBM_DEFINES_VH
`define SBM_OPERAND_W 8
`define SBM_PRODUCT_W 16
`define SBM_HIGH_MSB 15
`define SBM_HIGH_LSB 8
`define SBM_LOW_MSB 7
`define SBM_LOW_LSB 0
`define SBM_PRODUCT_HIGH_RST 8'h00
`define SBM_PRODUCT_LOW_RST 8'h00
`define SBM_STATUS_W 8
`define SBM_STATUS_RST 8'h00
`define SBM_OP_NONE 2'h0
`define SBM_OP_MUL_FILE 2'h1
`define SBM_OP_MUL_LIT 2'h2
`define SBM_OP_WRITE 2'h3
`endif

// ===== sbm_array_mult.v
// Combinational 8 by 8 unsigned array multiplier
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.vh"
module sbm_array_mult (
   input wire [`SBM_OPERAND_W-1:0] operand_a,
   input wire [`SBM_OPERAND_W-1:0] operand_b,
   output wire [`SBM_PRODUCT_W-1:0] product
);
   function [`SBM_PRODUCT_W-1:0] sbm_mul;
      input [`SBM_OPERAND_W-1:0] a;
      input [`SBM_OPERAND_W-1:0] b;
      integer i;
      reg [`SBM_PRODUCT_W-1:0] acc;
      begin
         acc = {`SBM_PRODUCT_W{1'b0}};
         for (i = 0; i < `SBM_OPERAND_W; i = i + 1) begin
            if (b[i]) begin
               acc = acc + ({8'h00, a} << i);
            end
         end
         sbm_mul = acc;
      end
   endfunction

   // Full width, no truncation
   assign product = sbm_mul(operand_a, operand_b);
endmodule // sbm_array_mult
`default_nettype wire

// ===== sbm_multiplier.v
// Product register pair and multiply control inside the arithmetic unit
// Functional notes
// - Hardware 8x8 multiply in one cycle
// - Unsigned operands, full 16-bit product
// - High byte and low byte registers updated
// - Multiply leaves arithmetic status flags unchanged
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.vh"
module sbm_multiplier (
   input wire sys_clk,
   input wire rst,
   input wire [1:0] op_sel,
   input wire [`SBM_OPERAND_W-1:0] working_register,
   input wire [`SBM_OPERAND_W-1:0] operand_file,
   input wire [`SBM_OPERAND_W-1:0] operand_literal,
   input wire write_high,
   input wire write_low,
   input wire [`SBM_OPERAND_W-1:0] write_data,
   input wire status_write,
   input wire [`SBM_STATUS_W-1:0] status_in,
   output reg [`SBM_OPERAND_W-1:0] product_high_byte,
   output reg [`SBM_OPERAND_W-1:0] product_low_byte,
   output reg [`SBM_STATUS_W-1:0] arith_status_reg,
   output wire mul_busy
);
   reg [`SBM_OPERAND_W-1:0] second_operand;
   wire [`SBM_PRODUCT_W-1:0] product;
   wire do_mul;
   wire load_high;
   wire load_low;
   wire status_load;
   wire [`SBM_OPERAND_W-1:0] mul_high;
   wire [`SBM_OPERAND_W-1:0] mul_low;
   reg [`SBM_OPERAND_W-1:0] next_product_high_byte;
   reg [`SBM_OPERAND_W-1:0] next_product_low_byte;
   reg [`SBM_STATUS_W-1:0] next_arith_status_reg;

   // Either multiply form
   function sbm_is_mul;
      input [1:0] op;
      begin
         case (op)
            `SBM_OP_NONE: begin
               sbm_is_mul = 1'b0;
            end
            `SBM_OP_MUL_FILE: begin
               sbm_is_mul = 1'b1;
            end
            `SBM_OP_MUL_LIT: begin
               sbm_is_mul = 1'b1;
            end
            `SBM_OP_WRITE: begin
               sbm_is_mul = 1'b0;
            end
            default: begin
               sbm_is_mul = 1'b0;
            end
         endcase
      end
   endfunction

   // Direct write strobe for one byte
   function sbm_byte_load;
      input [1:0] op;
      input strobe;
      begin
         case (op)
            `SBM_OP_NONE: begin
               sbm_byte_load = 1'b0;
            end
            `SBM_OP_MUL_FILE: begin
               sbm_byte_load = 1'b0;
            end
            `SBM_OP_MUL_LIT: begin
               sbm_byte_load = 1'b0;
            end
            `SBM_OP_WRITE: begin
               sbm_byte_load = strobe;
            end
            default: begin
               sbm_byte_load = 1'b0;
            end
         endcase
      end
   endfunction

   // Second operand for the selected form
   function [`SBM_OPERAND_W-1:0] sbm_pick_operand;
      input [1:0] op;
      input [`SBM_OPERAND_W-1:0] file_val;
      input [`SBM_OPERAND_W-1:0] lit_val;
      begin
         case (op)
            `SBM_OP_NONE: begin
               sbm_pick_operand = file_val;
            end
            `SBM_OP_MUL_FILE: begin
               sbm_pick_operand = file_val;
            end
            `SBM_OP_MUL_LIT: begin
               sbm_pick_operand = lit_val;
            end
            `SBM_OP_WRITE: begin
               sbm_pick_operand = file_val;
            end
            default: begin
               sbm_pick_operand = file_val;
            end
         endcase
      end
   endfunction

   // Operation decode
   assign do_mul = sbm_is_mul(op_sel);
   assign load_high = sbm_byte_load(op_sel, write_high);
   assign load_low = sbm_byte_load(op_sel, write_low);
   assign status_load = status_write && !do_mul;

   // Literal or file operand
   always @* begin
      second_operand = sbm_pick_operand(op_sel, operand_file, operand_literal);
   end

   // Never stalls
   assign mul_busy = 1'b0;

   sbm_array_mult u_mult (
      .operand_a(working_register),
      .operand_b(second_operand),
      .product(product)
   );

   // Full product split into its two bytes
   assign mul_high = product[`SBM_HIGH_MSB:`SBM_HIGH_LSB];
   assign mul_low = product[`SBM_LOW_MSB:`SBM_LOW_LSB];

   // High byte: multiply or direct write
   always @* begin
      next_product_high_byte = product_high_byte;
      case (op_sel)
         `SBM_OP_NONE: begin
            next_product_high_byte = product_high_byte;
         end
         `SBM_OP_MUL_FILE: begin
            next_product_high_byte = mul_high;
         end
         `SBM_OP_MUL_LIT: begin
            next_product_high_byte = mul_high;
         end
         `SBM_OP_WRITE: begin
            if (load_high) begin
               next_product_high_byte = write_data;
            end
         end
         default: begin
            next_product_high_byte = product_high_byte;
         end
      endcase
   end

   // Low byte: multiply or direct write
   always @* begin
      next_product_low_byte = product_low_byte;
      case (op_sel)
         `SBM_OP_NONE: begin
            next_product_low_byte = product_low_byte;
         end
         `SBM_OP_MUL_FILE: begin
            next_product_low_byte = mul_low;
         end
         `SBM_OP_MUL_LIT: begin
            next_product_low_byte = mul_low;
         end
         `SBM_OP_WRITE: begin
            if (load_low) begin
               next_product_low_byte = write_data;
            end
         end
         default: begin
            next_product_low_byte = product_low_byte;
         end
      endcase
   end

   // Status only changes on its own write, never by a multiply
   always @* begin
      if (status_load) begin
         next_arith_status_reg = status_in;
      end else begin
         next_arith_status_reg = arith_status_reg;
      end
   end

   // High product byte, readable next cycle
   always @(posedge sys_clk) begin
      if (rst) begin
         product_high_byte <= `SBM_PRODUCT_HIGH_RST;
      end else begin
         product_high_byte <= next_product_high_byte;
      end
   end

   // Low product byte, readable next cycle
   always @(posedge sys_clk) begin
      if (rst) begin
         product_low_byte <= `SBM_PRODUCT_LOW_RST;
      end else begin
         product_low_byte <= next_product_low_byte;
      end
   end

   // Status register
   always @(posedge sys_clk) begin
      if (rst) begin
         arith_status_reg <= `SBM_STATUS_RST;
      end else begin
         arith_status_reg <= next_arith_status_reg;
      end
   end
endmodule // sbm_multiplier
`default_nettype wire

// ===== sbm_chk_sva.sv
// Checker for the byte multiplier ports
`timescale 1ns/1ps
`default_nettype none
module sbm_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] op_sel,
   input wire logic [7:0] working_register,
   input wire logic [7:0] operand_file,
   input wire logic [7:0] operand_literal,
   input wire logic [7:0] product_high_byte,
   input wire logic [7:0] product_low_byte,
   input wire logic [7:0] arith_status_reg,
   input wire logic mul_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence mul_s; op_sel == 2'h1 || op_sel == 2'h2; endsequence
   sequence idle_s; op_sel == 2'h0; endsequence
   AST_NO_STALL: assert property (mul_busy == 1'b0) else $error("multiplier stalled");
   AST_FILE: assert property (op_sel == 2'h1 |=> {product_high_byte, product_low_byte} ==
      $past(working_register) * $past(operand_file)) else $error("file product wrong");
   AST_LIT: assert property (op_sel == 2'h2 |=> {product_high_byte, product_low_byte} ==
      $past(working_register) * $past(operand_literal)) else $error("literal product wrong");
   AST_FLAGS: assert property (mul_s |=> $stable(arith_status_reg)) else $error("flags moved");
   AST_HOLD: assert property (idle_s |=> $stable({product_high_byte, product_low_byte}))
      else $error("product changed");
endmodule // sbm_chk
`default_nettype wire

// ===== test_sbm_multiplier.sv
// Testbench for the byte multiplier
`timescale 1ns/1ps
`default_nettype none
module test_sbm_multiplier;
   logic sys_clk = 0, rst = 1, status_write = 0, write_high = 0, write_low = 0;
   logic [1:0] op_sel = 0;
   logic [7:0] working_register = 0, operand_file = 0, operand_literal = 0, write_data = 0, status_in = 0, a, b;
   logic [15:0] e;
   wire logic [7:0] product_high_byte, product_low_byte, arith_status_reg;
   wire logic mul_busy;
   int miscompares = 0, compares = 0;
   sbm_multiplier dut (.sys_clk, .rst, .op_sel, .working_register, .operand_file, .operand_literal, .write_high,
      .write_low, .write_data, .status_write, .status_in, .product_high_byte, .product_low_byte, .arith_status_reg,
      .mul_busy);
   always #5 sys_clk = ~sys_clk;
   task check(input string name, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task complete_run;
      if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task t_mul;
      @(posedge sys_clk) status_write <= 1'b1;
      status_in <= 8'h5a;
      for (int i = 0; i < 9; i++) begin
         @(posedge sys_clk);
         a = 8'hff - 8'(i * 29);
         b = 8'hff - 8'(i * 53);
         op_sel <= (i == 8) ? 2'h0 : {i[0], ~i[0]};
         working_register <= a;
         operand_file <= i[0] ? ~b : b;
         operand_literal <= i[0] ? b : ~b;
         status_in <= a;
         #1 if (i > 0) check("product", {product_high_byte, product_low_byte}, e);
         if (i > 0) check("status", {8'h00, arith_status_reg}, 16'h005a);
         e = a * b;
         status_write <= (i < 7);
      end
   endtask
   task t_signed;
      @(posedge sys_clk) op_sel <= 2'h1;
      working_register <= 8'h03;
      operand_file <= 8'hfe;
      @(posedge sys_clk) op_sel <= 2'h3;
      write_high <= 1'b1;
      write_data <= 8'hff;
      #1 check("unsigned", {product_high_byte, product_low_byte}, 16'h02fa);
      @(posedge sys_clk) op_sel <= 2'h0;
      #1 check("signed", {product_high_byte, product_low_byte}, 16'hfffa);
   endtask
   task t_write;
      @(posedge sys_clk) op_sel <= 2'h3;
      write_high <= 1'b0;
      write_low <= 1'b1;
      write_data <= 8'h3c;
      @(posedge sys_clk) op_sel <= 2'h0;
      write_data <= 8'hc3;
      #1 check("write low", {product_high_byte, product_low_byte}, 16'hff3c);
      @(posedge sys_clk) write_low <= 1'b0;
      status_write <= 1'b1;
      status_in <= 8'ha5;
      #1 check("refused write", {product_high_byte, product_low_byte}, 16'hff3c);
      @(posedge sys_clk) status_write <= 1'b0;
      #1 check("status write", {8'h00, arith_status_reg}, 16'h00a5);
      check("busy", {15'h0000, mul_busy}, 16'h0000);
   endtask
   task t_reset;
      @(posedge sys_clk) rst <= 1'b1;
      @(posedge sys_clk) rst <= 1'b0;
      op_sel <= 2'h1;
      working_register <= 8'hff;
      operand_file <= 8'hff;
      #1 check("mid reset", {product_high_byte, product_low_byte}, 16'h0000);
      check("status reset", {8'h00, arith_status_reg}, 16'h0000);
      @(posedge sys_clk) op_sel <= 2'h0;
      #1 check("after reset", {product_high_byte, product_low_byte}, 16'hfe01);
      check("status kept", {8'h00, arith_status_reg}, 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      #1 check("reset", {product_high_byte, product_low_byte}, 16'h0000);
      t_mul;
      t_signed;
      t_write;
      t_reset;
      complete_run;
   end
   initial begin
      repeat (500) @(posedge sys_clk);
      miscompares++;
      complete_run;
   end
endmodule // test_sbm_multiplier
bind sbm_multiplier sbm_chk chk (.sys_clk, .rst, .op_sel, .working_register, .operand_file, .operand_literal,
   .product_high_byte, .product_low_byte, .arith_status_reg, .mul_busy);
`default_nettype wire
